// >>> rtl/sba_pkg.sv
`default_nettype none

package sba_pkg;

    // Master codes double as indices into the request and grant vectors
    typedef enum logic [1:0] {
        SBA_CPU  = 2'b00,
        SBA_DMA  = 2'b01,
        SBA_RFSH = 2'b10,
        SBA_EXT  = 2'b11
    } sba_master_e;

    localparam int          SBA_NUM_MASTERS  = 4;
    localparam int          SBA_CODE_W       = 2;

    // Priority list, highest first in the top field
    localparam logic [7:0]  SBA_PRIO_DEFAULT = {SBA_RFSH, SBA_EXT, SBA_DMA, SBA_CPU};

    // Register port map
    localparam int          SBA_ADDR_W       = 2;
    localparam int          SBA_DATA_W       = 8;
    localparam logic [1:0]  SBA_REG_CTRL     = 2'h0;
    localparam logic [1:0]  SBA_REG_STATUS   = 2'h1;

    // Control register fields
    localparam int          SBA_CTRL_DBL_ACK = 0;
    localparam int          SBA_CTRL_RPL     = 1;
    localparam logic [1:0]  SBA_CTRL_RESET   = 2'h0;

    // Status register fields
    localparam int          SBA_ST_OWNER_LSB = 0;
    localparam int          SBA_ST_VALID     = 2;
    localparam int          SBA_ST_ABORT     = 3;
    localparam int          SBA_ST_REQ_LSB   = 4;

endpackage

`default_nettype wire

// >>> rtl/sba_arbiter.sv
// Notes on behaviour
// - A master pulling its request low is answered with its acknowledge low.
// - Simultaneous requests: only the highest priority requester is acknowledged.
// - Requests sampled every cycle; handover only at the owner's release point.
// - CPU loses the bus only while it runs no bus cycle.
// - No release between read and write of the atomic test-and-set.
// - Retry input low while the CPU retries keeps the bus with the CPU.
// - In double acknowledge mode no release during interrupt acknowledge.
// - CPU operations split over several bus cycles finish before release.
// - DMA yields to higher priority only between its bus cycles.
// - Burst DMA suspends for a higher requester and resumes afterwards.
// - Dual-address DMA read and write run with no arbitration between.
// - Bus error on a dual-address read aborts, skips the write, releases.
// - Several express channels: bus released after each express transfer if another master requests.
// - Refresh controller releases at each refresh cycle boundary.
// - Burst refresh with priority bit set: no arbitration until count zero.
// - External master requests on its pin and waits for its acknowledge.
`default_nettype none

module sba_arbiter #(
    parameter logic [7:0] PRIO_ORDER = sba_pkg::SBA_PRIO_DEFAULT  // Highest priority code in [7:6]
) (
    input  wire logic                          clk_sys,                // 40 MHz system clock
    input  wire logic                          reset_n,                // Synchronous reset
    input  wire logic                          cpu_req_n,              // CPU bus request
    output logic                               cpu_ack_n,              // CPU bus grant
    input  wire logic                          cpu_bus_cycle,          // CPU runs a bus cycle
    input  wire logic                          atomic_test_and_set,    // Atomic read-modify-write in progress
    input  wire logic                          bus_retry_n,            // Bus retry input
    input  wire logic                          cpu_int_ack,            // CPU interrupt acknowledge cycle
    input  wire logic                          cpu_split_op,           // Operation spans several bus cycles
    input  wire logic                          dma_req_n,              // DMA bus request
    output logic                               dma_ack_n,              // DMA bus grant
    input  wire logic                          dma_cycle_busy,         // DMA inside a bus cycle
    input  wire logic                          dma_dual_pending,       // Dual-address read done, write due
    input  wire logic                          bus_error_n,            // Bus error on current cycle
    input  wire logic                          dma_express_done,       // Express channel transfer completed
    output logic                               dma_abort,              // Abort dual transfer, skip write
    output logic                               dma_suspended,          // DMA requesting but not granted
    input  wire logic                          rfsh_req_n,             // Refresh bus request
    output logic                               rfsh_ack_n,             // Refresh bus grant
    input  wire logic                          rfsh_cycle_busy,        // Refresh cycle in progress
    input  wire logic                          rfsh_burst,             // Burst refresh active
    input  wire logic                          rfsh_count_zero,        // Refresh counter reached zero
    input  wire logic                          ext_bus_request_n,      // External master request pin
    output logic                               ext_bus_ack_n,          // External master acknowledge pin
    output logic                               refresh_priority_level, // Refresh priority bit to refresher
    input  wire logic [sba_pkg::SBA_ADDR_W-1:0] reg_addr,              // Register address
    input  wire logic [sba_pkg::SBA_DATA_W-1:0] reg_wdata,             // Register write data
    input  wire logic                          reg_wr,                 // Write strobe
    input  wire logic                          reg_rd,                 // Read strobe
    output logic      [sba_pkg::SBA_DATA_W-1:0] reg_rdata              // Read data, cycle after strobe
);

    // Highest priority requester: {found, code}
    function automatic logic [2:0] pick_winner(input logic [3:0] req, input logic [7:0] prio);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < sba_pkg::SBA_NUM_MASTERS; i++) begin
            if (!r[2] && req[prio[7-2*i -: 2]]) begin
                r = {1'b1, prio[7-2*i -: 2]};
            end
        end
        return r;
    endfunction

    sba_pkg::sba_master_e owner_r;
    sba_pkg::sba_master_e owner_nxt;
    logic                 own_valid_r;
    logic                 own_valid_nxt;
    logic                 dbl_ack_mode_r;
    logic                 rpl_r;
    logic                 retry_hold_r;
    logic                 cpu_cycle_q_r;
    logic                 express_yield_r;
    logic                 dma_abort_r;
    logic [3:0]           req_v;
    logic [3:0]           req_eff;
    logic [2:0]           win;
    logic                 abort_now;
    logic                 releasable;

    assign req_v     = ~{ext_bus_request_n, rfsh_req_n, dma_req_n, cpu_req_n};
    assign abort_now = own_valid_r && owner_r == sba_pkg::SBA_DMA && dma_dual_pending && !bus_error_n;

    // After an abort, or an express completion with another master requesting, the DMA request is held back once
    always_comb begin
        req_eff = req_v;
        if (express_yield_r || abort_now) begin
            req_eff[sba_pkg::SBA_DMA] = 1'b0;
        end
        if (express_yield_r && !abort_now && req_eff == 4'h0) begin
            req_eff = req_v;
        end
    end

    assign win = pick_winner(req_eff, PRIO_ORDER);

    // Release point of the current owner
    always_comb begin
        releasable = 1'b1;
        unique case (owner_r)
            sba_pkg::SBA_CPU: begin
                releasable = !cpu_bus_cycle
                           && !atomic_test_and_set
                           && bus_retry_n && !retry_hold_r
                           && !(dbl_ack_mode_r && cpu_int_ack)
                           && !cpu_split_op;
            end
            sba_pkg::SBA_DMA: begin
                releasable = (!dma_cycle_busy && !dma_dual_pending) || abort_now;
            end
            sba_pkg::SBA_RFSH: begin
                releasable = !rfsh_cycle_busy
                           && !(rfsh_burst && rpl_r && !rfsh_count_zero);
            end
            sba_pkg::SBA_EXT: begin
                releasable = !req_v[sba_pkg::SBA_EXT];
            end
        endcase
    end

    always_comb begin
        owner_nxt     = owner_r;
        own_valid_nxt = own_valid_r;
        if (!own_valid_r) begin
            owner_nxt     = sba_pkg::sba_master_e'(win[1:0]);
            own_valid_nxt = win[2];
        end else if (releasable && (!req_eff[owner_r] || win[1:0] != owner_r)) begin
            // A higher winner pre-empts; a suspended burst DMA wins back later
            owner_nxt     = sba_pkg::sba_master_e'(win[1:0]);
            own_valid_nxt = win[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            owner_r     <= sba_pkg::SBA_CPU;
            own_valid_r <= 1'b0;
        end else begin
            owner_r     <= owner_nxt;
            own_valid_r <= own_valid_nxt;
        end
    end

    // Retry hold lasts until the retried CPU cycle has ended
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            retry_hold_r  <= 1'b0;
            cpu_cycle_q_r <= 1'b0;
        end else begin
            cpu_cycle_q_r <= cpu_bus_cycle;
            if (!bus_retry_n && own_valid_r && owner_r == sba_pkg::SBA_CPU) begin
                retry_hold_r <= 1'b1;
            end else if (cpu_cycle_q_r && !cpu_bus_cycle) begin
                retry_hold_r <= 1'b0;
            end
        end
    end

    // Set wins over clear when a completion lands with the handover
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            express_yield_r <= 1'b0;
        end else if (dma_express_done && own_valid_r && owner_r == sba_pkg::SBA_DMA) begin
            express_yield_r <= 1'b1;
        end else if (!dma_cycle_busy) begin
            express_yield_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dma_abort_r <= 1'b0;
        end else begin
            dma_abort_r <= abort_now;
        end
    end

    // Register port
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dbl_ack_mode_r <= sba_pkg::SBA_CTRL_RESET[sba_pkg::SBA_CTRL_DBL_ACK];
            rpl_r          <= sba_pkg::SBA_CTRL_RESET[sba_pkg::SBA_CTRL_RPL];
        end else if (reg_wr && reg_addr == sba_pkg::SBA_REG_CTRL) begin
            dbl_ack_mode_r <= reg_wdata[sba_pkg::SBA_CTRL_DBL_ACK];
            rpl_r          <= reg_wdata[sba_pkg::SBA_CTRL_RPL];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd && reg_addr == sba_pkg::SBA_REG_CTRL) begin
                reg_rdata[sba_pkg::SBA_CTRL_DBL_ACK] <= dbl_ack_mode_r;
                reg_rdata[sba_pkg::SBA_CTRL_RPL]     <= rpl_r;
            end else if (reg_rd && reg_addr == sba_pkg::SBA_REG_STATUS) begin
                reg_rdata[sba_pkg::SBA_ST_OWNER_LSB +: 2] <= owner_r;
                reg_rdata[sba_pkg::SBA_ST_VALID]          <= own_valid_r;
                reg_rdata[sba_pkg::SBA_ST_ABORT]          <= dma_abort_r;
                reg_rdata[sba_pkg::SBA_ST_REQ_LSB +: 4]   <= req_v;
            end
        end
    end

    // Grants are decoded through gates from the owner and valid flops, not registered one per master
    assign cpu_ack_n     = !(own_valid_r && owner_r == sba_pkg::SBA_CPU);
    assign dma_ack_n     = !(own_valid_r && owner_r == sba_pkg::SBA_DMA);
    assign rfsh_ack_n    = !(own_valid_r && owner_r == sba_pkg::SBA_RFSH);
    assign ext_bus_ack_n = !(own_valid_r && owner_r == sba_pkg::SBA_EXT);
    assign dma_abort     = dma_abort_r;
    assign dma_suspended = !dma_req_n && dma_ack_n;
    assign refresh_priority_level = rpl_r;

    logic [2:0] win_q_r;
    logic       idle_q_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            win_q_r  <= 3'h0;
            idle_q_r <= 1'b1;
        end else begin
            win_q_r  <= win;
            idle_q_r <= !own_valid_r;
        end
    end

    a_grant_onehot: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $onehot0(~{cpu_ack_n, dma_ack_n, rfsh_ack_n, ext_bus_ack_n}))
        else $error("more than one acknowledge active");

    a_idle_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!own_valid_r && |req_v) |=> (own_valid_r && owner_r == win_q_r[1:0]))
        else $error("idle bus not granted to highest requester");

    a_cpu_cycle_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cpu_ack_n && cpu_bus_cycle) |=> !cpu_ack_n)
        else $error("bus taken from cpu during a bus cycle");

    a_tas_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cpu_ack_n && atomic_test_and_set) |=> !cpu_ack_n)
        else $error("bus released inside atomic sequence");

    a_retry_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cpu_ack_n && !bus_retry_n) |=> !cpu_ack_n ##0 retry_hold_r)
        else $error("bus released during retry");

    a_intack_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cpu_ack_n && cpu_int_ack && dbl_ack_mode_r) |=> !cpu_ack_n)
        else $error("bus released during interrupt acknowledge");

    a_split_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cpu_ack_n && cpu_split_op) |=> !cpu_ack_n)
        else $error("bus released inside split operation");

    a_dma_cycle_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!dma_ack_n && dma_cycle_busy && !dma_dual_pending) |=> !dma_ack_n)
        else $error("dma lost bus inside a bus cycle");

    a_dual_pair: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!dma_ack_n && dma_dual_pending && bus_error_n) |=> !dma_ack_n)
        else $error("arbitration between dual-address read and write");

    a_berr_abort: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!dma_ack_n && dma_dual_pending && !bus_error_n) |=> (dma_ack_n && dma_abort))
        else $error("bus error did not abort and release dma");

    a_rpl_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!rfsh_ack_n && rfsh_burst && rpl_r && !rfsh_count_zero) |=> !rfsh_ack_n)
        else $error("arbitration during priority burst refresh");

    a_ext_needs_req: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(ext_bus_ack_n) |-> !$past(ext_bus_request_n))
        else $error("external acknowledge without request");

    a_dma_preempt: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!dma_ack_n && !dma_cycle_busy && !dma_dual_pending && !rfsh_req_n
         && PRIO_ORDER[7:6] == sba_pkg::SBA_RFSH) |=> !rfsh_ack_n ##0 (dma_suspended || dma_req_n))
        else $error("dma not pre-empted by higher requester");

    c_dma_preempted: cover property (@(posedge clk_sys) disable iff (!reset_n)
        !dma_ack_n ##1 dma_suspended [*2] ##1 !dma_ack_n);

    c_berr_abort: cover property (@(posedge clk_sys) disable iff (!reset_n)
        dma_abort);

    c_ext_grant: cover property (@(posedge clk_sys) disable iff (!reset_n)
        !cpu_ack_n ##[1:20] !ext_bus_ack_n);

    c_express_yield: cover property (@(posedge clk_sys) disable iff (!reset_n)
        express_yield_r ##1 !rfsh_ack_n);

    c_idle_return: cover property (@(posedge clk_sys) disable iff (!reset_n)
        idle_q_r ##1 !own_valid_r ##1 own_valid_r);

endmodule

`default_nettype wire

// >>> testbench/sba_master_model.sv
`default_nettype none

// Behavioural stand-in for the four masters around the arbiter
module sba_master_model (
    input  wire logic       clk_sys,  // System clock
    input  wire logic       reset_n,  // Synchronous reset, active low
    input  wire logic [3:0] want,     // Masters wanting the bus, indexed by master code
    input  wire logic [3:0] ack_n,    // Grants seen, indexed by master code
    output logic      [3:0] req_n,    // Requests towards the arbiter
    output logic      [3:0] bus_use,  // Masters actually driving the bus
    output logic            overlap   // Sticky: two masters drove the bus at once
);
    timeunit 1ns;
    timeprecision 1ps;

    // Requests are plain levels; the external master uses its own pin, bit 3
    assign req_n = ~want;

    // A master touches the bus only while it wants it and its grant is low
    assign bus_use = want & ~ack_n;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            overlap <= 1'h0;
        end else if ($countones(bus_use) > 1) begin
            overlap <= 1'h1;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys = 1'h0;
    logic       reset_n = 1'h0;
    logic [3:0] want = 4'h0;
    logic       cpu_bus_cycle = 1'h0, atomic_test_and_set = 1'h0, bus_retry_n = 1'h1, cpu_int_ack = 1'h0;
    logic       cpu_split_op = 1'h0, dma_cycle_busy = 1'h0, dma_dual_pending = 1'h0, bus_error_n = 1'h1;
    logic       dma_express_done = 1'h0, rfsh_cycle_busy = 1'h0, rfsh_burst = 1'h0, rfsh_count_zero = 1'h1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'h0, reg_rd = 1'h0;
    wire logic [3:0] req_n, bus_use, ackv;
    wire logic       cpu_ack_n, dma_ack_n, rfsh_ack_n, ext_bus_ack_n, overlap;
    wire logic       dma_abort, dma_suspended, refresh_priority_level;
    wire logic [7:0] reg_rdata;
    int              errors = 0, tests_run = 0;
    logic [7:0]      d;

    assign ackv = {ext_bus_ack_n, rfsh_ack_n, dma_ack_n, cpu_ack_n};

    always #12.5 clk_sys = ~clk_sys;

    sba_master_model i_model (.clk_sys(clk_sys), .reset_n(reset_n), .want(want), .ack_n(ackv),
        .req_n(req_n), .bus_use(bus_use), .overlap(overlap));

    sba_arbiter #(.PRIO_ORDER(sba_pkg::SBA_PRIO_DEFAULT)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .cpu_req_n(req_n[0]), .cpu_ack_n(cpu_ack_n),
        .cpu_bus_cycle(cpu_bus_cycle), .atomic_test_and_set(atomic_test_and_set), .bus_retry_n(bus_retry_n),
        .cpu_int_ack(cpu_int_ack), .cpu_split_op(cpu_split_op), .dma_req_n(req_n[1]), .dma_ack_n(dma_ack_n),
        .dma_cycle_busy(dma_cycle_busy), .dma_dual_pending(dma_dual_pending), .bus_error_n(bus_error_n),
        .dma_express_done(dma_express_done), .dma_abort(dma_abort), .dma_suspended(dma_suspended),
        .rfsh_req_n(req_n[2]), .rfsh_ack_n(rfsh_ack_n), .rfsh_cycle_busy(rfsh_cycle_busy),
        .rfsh_burst(rfsh_burst), .rfsh_count_zero(rfsh_count_zero), .ext_bus_request_n(req_n[3]),
        .ext_bus_ack_n(ext_bus_ack_n), .refresh_priority_level(refresh_priority_level),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic wrap_up;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Every task below starts and ends right after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Grant after n edges, checked once the edge's updates have landed
    task automatic grant_is(input int n, input logic [3:0] e);
        cyc(n);
        #1;
        chk(8'(ackv), 8'(e));
        cyc(1);
    endtask

    task automatic wait_ack(input logic [3:0] e);
        int k;
        k = 0;
        #1;
        while (ackv !== e && k < 8) begin
            cyc(1);
            #1;
            k++;
        end
        chk(8'(ackv), 8'(e));
        if (ackv !== e) wrap_up();
        cyc(1);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        cyc(1);
        reg_wr <= 1'h0;
        cyc(1);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'h1;
        cyc(1);
        reg_rd <= 1'h0;
        #1;
        v = reg_rdata;
        cyc(1);
    endtask

    task automatic sc_regs;
        rd(2'h0, d);
        chk(d, 8'h00);
        wr(2'h0, 8'h03);
        rd(2'h0, d);
        chk(d, 8'h03);
        chk(8'(refresh_priority_level), 8'h01);
        wr(2'h1, 8'hFF);
        rd(2'h2, d);
        chk(d, 8'h00);
        rd(2'h1, d);
        chk(d, 8'h00);
        wr(2'h0, 8'h00);
    endtask

    task automatic sc_prio;
        want <= 4'hF;
        grant_is(1, 4'hB);
        rd(2'h1, d);
        chk(d, 8'hF6);
        want <= 4'hB;
        grant_is(1, 4'h7);
        want <= 4'h3;
        grant_is(1, 4'hD);
        want <= 4'h1;
        grant_is(1, 4'hE);
        want <= 4'h0;
        grant_is(1, 4'hF);
    endtask

    task automatic sc_cpu_walk;
        want <= 4'h1;
        cpu_bus_cycle <= 1'h1;
        grant_is(1, 4'hE);
        want <= 4'h5;
        grant_is(3, 4'hE);
        cpu_bus_cycle <= 1'h0;
        grant_is(1, 4'hB);
        want <= 4'h0;
        cyc(2);
    endtask

    task automatic set_hold(input int i, input logic v);
        case (i)
            0: atomic_test_and_set <= v;
            1: bus_retry_n <= ~v;
            2: cpu_int_ack <= v;
            default: cpu_split_op <= v;
        endcase
    endtask

    // Each hold case keeps the CPU on the bus although it runs no bus cycle
    task automatic sc_cpu_hold;
        wr(2'h0, 8'h01);
        for (int i = 0; i < 4; i++) begin
            want <= 4'h1;
            cyc(2);
            set_hold(i, 1'h1);
            want <= 4'h5;
            grant_is(4, 4'hE);
            set_hold(i, 1'h0);
            cpu_bus_cycle <= 1'h1;
            cyc(1);
            cpu_bus_cycle <= 1'h0;
            wait_ack(4'hB);
            want <= 4'h0;
            cyc(2);
        end
        wr(2'h0, 8'h00);
    endtask

    task automatic sc_dma;
        want <= 4'h2;
        dma_cycle_busy <= 1'h1;
        grant_is(1, 4'hD);
        want <= 4'h6;
        grant_is(3, 4'hD);
        dma_cycle_busy <= 1'h0;
        dma_dual_pending <= 1'h1;
        grant_is(3, 4'hD);
        bus_error_n <= 1'h0;
        cyc(1);
        #1;
        chk(8'(ackv), 8'h0B);
        chk(8'(dma_abort), 8'h01);
        chk(8'(dma_suspended), 8'h01);
        cyc(1);
        bus_error_n <= 1'h1;
        dma_dual_pending <= 1'h0;
        #1;
        chk(8'(dma_abort), 8'h00);
        cyc(1);
        want <= 4'h2;
        grant_is(1, 4'hD);
        want <= 4'h3;
        dma_express_done <= 1'h1;
        cyc(1);
        dma_express_done <= 1'h0;
        // The completion is seen at one edge and DMA is held back at the next
        cyc(1);
        #1;
        chk(8'(ackv), 8'h0E);
        cyc(1);
        want <= 4'h2;
        wait_ack(4'hD);
        want <= 4'h6;
        cyc(1);
        #1;
        chk(8'(ackv), 8'h0B);
        chk(8'(dma_suspended), 8'h01);
        cyc(1);
        want <= 4'h2;
        grant_is(1, 4'hD);
        want <= 4'h0;
        cyc(2);
    endtask

    task automatic sc_rfsh;
        want <= 4'h4;
        rfsh_cycle_busy <= 1'h1;
        grant_is(1, 4'hB);
        want <= 4'h8;
        grant_is(3, 4'hB);
        rfsh_cycle_busy <= 1'h0;
        grant_is(1, 4'h7);
        want <= 4'hC;
        grant_is(3, 4'h7);
        want <= 4'h0;
        wait_ack(4'hF);
        wr(2'h0, 8'h02);
        want <= 4'h4;
        rfsh_burst <= 1'h1;
        rfsh_count_zero <= 1'h0;
        cyc(2);
        want <= 4'h8;
        grant_is(4, 4'hB);
        rfsh_count_zero <= 1'h1;
        wait_ack(4'h7);
        rfsh_burst <= 1'h0;
        want <= 4'h0;
        wr(2'h0, 8'h00);
    endtask

    // A hang anywhere ends the run through the same closing report
    initial begin
        cyc(5000);
        errors++;
        wrap_up();
    end

    initial begin
        cyc(3);
        #1;
        chk(8'(ackv), 8'h0F);
        chk(8'(refresh_priority_level), 8'h00);
        chk(reg_rdata, 8'h00);
        cyc(1);
        reset_n <= 1'h1;
        cyc(1);
        sc_regs();
        sc_prio();
        sc_cpu_walk();
        sc_cpu_hold();
        sc_dma();
        sc_rfsh();
        chk(8'(overlap), 8'h00);
        wrap_up();
    end
endmodule

`default_nettype wire
